// File: include/cdb_pkg.sv
package cdb_pkg;
   localparam int unsigned DATA_W   = 8;
   localparam logic [7:0]  ONE_8    = 8'h01;
   localparam logic [3:0]  BCD_LIM  = 4'h9;
   localparam logic [7:0]  ADJ_LO   = 8'h06;
   localparam logic [7:0]  ADJ_HI   = 8'h60;
   localparam logic        DEST_ACC = 1'b0;
   localparam logic        DEST_REG = 1'b1;

   // operation select
   typedef enum logic [2:0] {
      CDB_OP_NONE = 3'h0,
      compare_reg_acc_op = 3'h1,
      decrement_reg_op = 3'h2,
      decimal_adjust_op = 3'h3,
      decrement_skip_zero_op = 3'h4
   } cdb_op_t;

   // skip sequencer states
   typedef enum logic [1:0] {
      CDB_ST_RUN  = 2'b00,
      CDB_ST_SKIP = 2'b01
   } cdb_state_t;
endpackage : cdb_pkg

// File: rtl/cdb_alu.sv
`timescale 1ns/1ps
`default_nettype none
module cdb_alu
   import cdb_pkg::*;
#(
   parameter int unsigned W = DATA_W
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         op_valid,
   input  wire cdb_op_t      op,
   input  wire logic         dest,
   input  wire logic [W-1:0] reg_data,
   input  wire logic [W-1:0] accumulator,
   input  wire logic         carry_in,
   input  wire logic         half_carry_in,
   output logic              op_ready,
   output logic [W-1:0]      result,
   output logic              acc_we,
   output logic              reg_we,
   output logic              zero_we,
   output logic              zero_flag,
   output logic              carry_we,
   output logic              carry_flag,
   output logic              skip_next
);
   cdb_state_t state;
   cdb_state_t next_state;

   // operation decode, gated off while a skip slot runs
   wire logic take     = op_valid & (state == CDB_ST_RUN);
   wire logic is_cmp   = take & (op == compare_reg_acc_op);
   wire logic is_dec   = take & (op == decrement_reg_op);
   wire logic is_dsz   = take & (op == decrement_skip_zero_op);
   wire logic is_daa   = take & (op == decimal_adjust_op);
   wire logic any_dec  = is_dec | is_dsz;

   wire logic [W:0]   cmp_sum  = {1'b0, reg_data} + {1'b0, ~accumulator} + {{W{1'b0}}, 1'b1};
   wire logic [W-1:0] cmp_diff = cmp_sum[W-1:0];
   wire logic         cmp_c    = cmp_sum[W];
   wire logic         cmp_z    = (cmp_diff == '0);

   wire logic [W-1:0] dec_val  = reg_data - W'(ONE_8);
   wire logic         dec_z    = (dec_val == '0);

   wire logic         lo_fix   = half_carry_in | (accumulator[3:0] > BCD_LIM);
   wire logic [W-1:0] acc_lo   = accumulator + (lo_fix ? W'(ADJ_LO) : '0);
   wire logic         hi_fix   = carry_in | (accumulator > 8'h99);
   wire logic [W:0]   daa_sum  = {1'b0, acc_lo} + {1'b0, (hi_fix ? W'(ADJ_HI) : '0)};
   wire logic         daa_c    = hi_fix | daa_sum[W];

   // result select
   wire logic [W-1:0] sel_data = any_dec ? dec_val : (is_daa ? daa_sum[W-1:0] : cmp_diff);
   wire logic sel_acc = (any_dec & (dest == DEST_ACC)) | is_daa;
   wire logic sel_reg = any_dec & (dest == DEST_REG);
   wire logic sel_zwe = is_cmp | any_dec;
   wire logic sel_z   = is_cmp ? cmp_z : dec_z;
   wire logic sel_cwe = is_cmp | is_daa;
   wire logic sel_c   = is_cmp ? cmp_c : daa_c;

   // skip when a decrement_skip_zero_op result is zero
   wire logic skip_now = is_dsz & dec_z;

   // extra nop cycle on a taken skip
   always_comb begin
      next_state = state;
      case (state)
         CDB_ST_RUN:  next_state = skip_now ? CDB_ST_SKIP : CDB_ST_RUN;
         CDB_ST_SKIP: next_state = CDB_ST_RUN;
         default:     next_state = CDB_ST_RUN;
      endcase
   end

   // sequencer state and skip request register
   always_ff @(posedge clk) begin
      if (rst) begin
         state     <= CDB_ST_RUN;
         skip_next <= 1'b0;
      end else begin
         state     <= next_state;
         skip_next <= skip_now;
      end
   end

   assign op_ready = (state == CDB_ST_RUN);

   cdb_result_reg #(
      .W (W)
   ) u_res (
      .clk         (clk),
      .rst         (rst),
      .load        (take),
      .next_data   (sel_data),
      .next_acc_we (sel_acc),
      .next_reg_we (sel_reg),
      .next_z_we   (sel_zwe),
      .next_z      (sel_z),
      .next_c_we   (sel_cwe),
      .next_c      (sel_c),
      .data        (result),
      .acc_we      (acc_we),
      .reg_we      (reg_we),
      .z_we        (zero_we),
      .z           (zero_flag),
      .c_we        (carry_we),
      .c           (carry_flag)
   );
endmodule : cdb_alu
`default_nettype wire

// File: rtl/cdb_result_reg.sv
`timescale 1ns/1ps
`default_nettype none
// registered result and flag outputs
module cdb_result_reg #(
   parameter int unsigned W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         load,
   input  wire logic [W-1:0] next_data,
   input  wire logic         next_acc_we,
   input  wire logic         next_reg_we,
   input  wire logic         next_z_we,
   input  wire logic         next_z,
   input  wire logic         next_c_we,
   input  wire logic         next_c,
   output logic [W-1:0]      data,
   output logic              acc_we,
   output logic              reg_we,
   output logic              z_we,
   output logic              z,
   output logic              c_we,
   output logic              c
);
   // strobes last one cycle, data and flags hold
   always_ff @(posedge clk) begin
      if (rst) begin
         data   <= '0;
         acc_we <= 1'b0;
         reg_we <= 1'b0;
         z_we   <= 1'b0;
         z      <= 1'b0;
         c_we   <= 1'b0;
         c      <= 1'b0;
      end else begin
         acc_we <= load & next_acc_we;
         reg_we <= load & next_reg_we;
         z_we   <= load & next_z_we;
         c_we   <= load & next_c_we;
         if (load) begin
            data <= next_data;
         end
         // a flag moves only when its own write strobe is raised
         if (load & next_z_we) begin
            z <= next_z;
         end
         if (load & next_c_we) begin
            c <= next_c;
         end
      end
   end
endmodule : cdb_result_reg
`default_nettype wire

// File: verif/cdb_chk.sv
`timescale 1ns/1ps
`default_nettype none
// port checks on the alu
module cdb_chk
   import cdb_pkg::*;
(
   input wire logic       clk, rst, op_valid, dest, carry_in, half_carry_in, op_ready,
   input wire cdb_op_t    op,
   input wire logic [7:0] reg_data, accumulator, result,
   input wire logic       acc_we, reg_we, zero_we, zero_flag, carry_we, carry_flag, skip_next
);
   wire t = op_valid && op_ready;
   wire s = t && op == decrement_skip_zero_op;
   wire d = s || t && op == decrement_reg_op;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_CMP: assert property (t && op == compare_reg_acc_op |=>
      zero_we && carry_we && !acc_we && !reg_we && zero_flag == ($past(reg_data) == $past(accumulator))
      && carry_flag == ($past(reg_data) >= $past(accumulator))) else $error("cmp");
   AST_DEC: assert property (d |=> zero_we && result == $past(reg_data) - ONE_8
      && zero_flag == (result == 8'h00)) else $error("dec");
   AST_DECC: assert property (d |=> !carry_we && $stable(carry_flag))
      else $error("dec carry");
   AST_DEST: assert property (d |=> acc_we != $past(dest) && reg_we == $past(dest))
      else $error("dest");
   AST_SKIP: assert property (s && reg_data == ONE_8 |=> skip_next && !op_ready ##1
      op_ready && !skip_next) else $error("skip");
   AST_NOSKIP: assert property (s && reg_data != ONE_8 |=> !skip_next && op_ready)
      else $error("noskip");
   AST_DAA: assert property (t && op == decimal_adjust_op |=> acc_we && carry_we
      && !reg_we && !zero_we) else $error("daa");
   AST_IDLE: assert property (!t |=> !(acc_we | reg_we | zero_we | carry_we | skip_next))
      else $error("idle");
   AST_HOLD: assert property (!t |=> $stable(zero_flag) && $stable(carry_flag))
      else $error("hold");
endmodule : cdb_chk
bind cdb_alu cdb_chk cdb_chk_i (.clk, .rst, .op_valid, .dest, .carry_in, .half_carry_in,
   .op_ready, .op, .reg_data, .accumulator, .result, .acc_we, .reg_we, .zero_we, .zero_flag,
   .carry_we, .carry_flag, .skip_next);
`default_nettype wire

// File: verif/cdb_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
// fetch side: offers a fetched op each cycle it holds one
module cdb_fetch_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic want,
   output var logic op_valid
);
   // no interrupt slot is ever inserted between ops
   always_ff @(posedge clk) begin
      op_valid <= want && !rst;
   end
endmodule : cdb_fetch_model
`default_nettype wire

// File: verif/compare_decrement_bcd_alu_ops_bench.sv
`timescale 1ns/1ps
`default_nettype none
module compare_decrement_bcd_alu_ops_bench
   import cdb_pkg::*;
;
   logic clk = 0, rst = 1, want = 0, dest = 0, carry_in = 0, half_carry_in = 0, pend = 0;
   cdb_op_t op = CDB_OP_NONE;
   logic [7:0] reg_data = 0, accumulator = 0, result;
   logic op_valid, op_ready, acc_we, reg_we, zero_we, zero_flag, carry_we, carry_flag, skip_next;
   logic [14:0] expv;
   int mismatches = 0, n_checks = 0;
   always #10 clk = ~clk;
   cdb_alu cdb_alu_i (.clk, .rst, .op_valid, .op, .dest, .reg_data, .accumulator, .carry_in,
      .half_carry_in, .op_ready, .result, .acc_we, .reg_we, .zero_we, .zero_flag, .carry_we,
      .carry_flag, .skip_next);
   cdb_fetch_model cdb_fetch_model_i (.clk, .rst, .want, .op_valid);
   // strobes, masked flags and result expected one cycle after a taken op
   function automatic logic [14:0] f(cdb_op_t o, logic d, logic [7:0] r, a, logic c, h);
      logic [8:0] s;
      logic       lo, hi;
      lo = h || a[3:0] > BCD_LIM;
      hi = c || a > 8'h99;
      s = {1'b0, a} + (lo ? ADJ_LO : 8'h00) + (hi ? ADJ_HI : 8'h00);
      case (o)
         compare_reg_acc_op: return {3'b001, r == a, 1'b1, r >= a, 1'b0, r - a};
         decrement_reg_op, decrement_skip_zero_op: return {!d, d, 1'b1, r == ONE_8, 2'b00,
            o == decrement_skip_zero_op && r == ONE_8, r - ONE_8};
         decimal_adjust_op: return {4'b1000, 1'b1, hi || s[8], 1'b0, s[7:0]};
         default: return 15'h0000;
      endcase
   endfunction : f
   task automatic check(logic [14:0] seen, logic [14:0] exp_v);
      n_checks++;
      if (seen !== exp_v) begin
         mismatches++;
         $display("BAD %0t alu got %h want %h", $time, seen, exp_v);
      end
   endtask : check
   task automatic summarize;
      if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   // random op stream, biased to register 01 and operand 4d
   initial begin
      void'($urandom(32'hbac07dd6));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (3000) begin
         @(negedge clk);
         check({acc_we, reg_we, zero_we, zero_we & zero_flag, carry_we, carry_we & carry_flag,
            skip_next, (acc_we | reg_we | zero_we) ? result : 8'h00}, pend ? expv : 15'h0);
         pend = op_valid && op_ready;
         expv = f(op, dest, reg_data, accumulator, carry_in, half_carry_in);
         @(posedge clk);
         want <= $urandom_range(0, 3) != 0;
         op <= cdb_op_t'($urandom_range(0, 7));
         dest <= 1'($urandom);
         reg_data <= $urandom_range(0, 2) == 0 ? ONE_8 : $urandom_range(0, 1) ? 8'h4d : 8'($urandom);
         accumulator <= $urandom_range(0, 1) ? 8'h4d : 8'($urandom);
         {carry_in, half_carry_in} <= 2'($urandom);
      end
      summarize();
   end
   // watchdog against a hung run
   initial begin
      #80us;
      mismatches++;
      summarize();
   end
endmodule : compare_decrement_bcd_alu_ops_bench
`default_nettype wire
